/* flash_access_guard.sv */
// Purpose: checks each flash access against enables, lock byte and source
// Assumes: lock_byte_in shows the stored lock byte whenever sampled
// Notes:   one request per cycle; every verdict appears one cycle later
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module flash_access_guard
    import flash_guard_pkg::*;
#(
    parameter logic [7:0] PART_ID = 8'h5A // arbitrary value
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // access requests from core and debug port
    input wire access_req_t req,
    output logic req_ready,
    input wire logic full_chip_wipe,
    input wire logic [7:0] lock_byte_in,
    // verdicts
    output flash_cmd_t flash_cmd,
    output logic aux_ram_sel,
    output logic debug_ignored,
    output logic flash_fault_device_reset,
    output logic id_valid,
    output logic [7:0] id_data
);

    // ------------------------------------------------------------
    // software visible state
    // ------------------------------------------------------------
    logic [2:0] program_store_control_q;
    logic [3:0] reset_cause_register_q;
    logic [7:0] lock_n_q;
    logic lock_written_q;
    logic latch_pend_q;
    logic fault_q;

    // ------------------------------------------------------------
    // ahb-lite slave, zero wait states
    // ------------------------------------------------------------
    logic wr_pend_q;
    logic [7:0] ap_addr_q;
    logic [31:0] rd_word;
    logic ap_take;

    assign ap_take = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= ap_take && hwrite;
            if (ap_take) begin
                ap_addr_q <= haddr[7:0];
            end
        end
    end

    // unmapped offsets read as zero and swallow writes
    // read word is captured in the address phase so it stands for the
    // whole data phase; a write still in its data phase is not seen yet
    always_comb begin
        rd_word = 32'h0000_0000;
        if (haddr[7:0] == OFS_CTRL) begin
            rd_word[2:0] = program_store_control_q;
        end else if (haddr[7:0] == OFS_CAUSE) begin
            rd_word[3:0] = reset_cause_register_q;
        end else if (haddr[7:0] == OFS_STATUS) begin
            rd_word[7:0] = lock_n_q;
            rd_word[STAT_WRITTEN] = lock_written_q;
            rd_word[STAT_ID_LSB +: 8] = PART_ID;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata <= rd_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            program_store_control_q <= CTRL_RESET;
        end else if (wr_pend_q && ap_addr_q == OFS_CTRL) begin
            program_store_control_q <= hwdata[2:0];
        end
    end

    // flags only clear where software writes zero; a set in the same
    // cycle wins so no fault is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_cause_register_q <= CAUSE_RESET;
        end else begin
            if (wr_pend_q && ap_addr_q == OFS_CAUSE) begin
                reset_cause_register_q[CAUSE_MON_EN] <= hwdata[CAUSE_MON_EN];
                reset_cause_register_q[CAUSE_MON_RST] <=
                    hwdata[CAUSE_MON_RST];
                reset_cause_register_q[CAUSE_POR] <=
                    reset_cause_register_q[CAUSE_POR] && hwdata[CAUSE_POR];
                reset_cause_register_q[CAUSE_FAULT] <=
                    reset_cause_register_q[CAUSE_FAULT] && hwdata[CAUSE_FAULT];
            end
            if (fault_q) begin
                reset_cause_register_q[CAUSE_FAULT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // lock decode, latched at reset only
    // ------------------------------------------------------------
    // a fault reset re-arms the latch so a freshly written lock byte
    // takes effect then, never mid-run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_pend_q <= 1'b1;
            lock_n_q <= 8'h00;
        end else if (latch_pend_q) begin
            latch_pend_q <= 1'b0;
            lock_n_q <= ~lock_byte_in;
        end else if (fault_q) begin
            latch_pend_q <= 1'b1;
        end else if (full_chip_wipe) begin
            lock_n_q <= 8'h00;
        end
    end

    assign req_ready = !latch_pend_q && !fault_q;

    // ------------------------------------------------------------
    // permission check
    // ------------------------------------------------------------
    logic any_lock;
    logic tgt_scratch;
    logic tgt_locked;
    logic src_locked;
    logic eff_write;
    logic eff_erase;
    logic is_read;
    logic is_lock_page;
    logic in_reserved;
    logic monitor_ok;
    logic deny;
    logic to_aux;
    logic id_read;

    function automatic logic page_locked(input logic [15:0] a,
                                         input logic [7:0] n);
        logic [7:0] idx;
        idx = {2'b00, a[15:PAGE_SHIFT]};
        page_locked = (idx < n) || (a[15:PAGE_SHIFT] == LOCK_PAGE &&
                                    n != 8'h00);
    endfunction

    assign any_lock = lock_n_q != 8'h00;
    assign tgt_scratch = program_store_control_q[CTRL_SCR_EN] &&
                         req.addr <= SCRATCH_LAST;
    // scratchpad counts as locked once all user pages are locked
    assign tgt_locked = tgt_scratch ?
                        (lock_n_q >= {2'b00, LOCK_PAGE}) :
                        page_locked(req.addr, lock_n_q);
    assign src_locked = page_locked(req.fetch_addr, lock_n_q);
    assign is_read = req.op == OP_CODE_READ;
    // firmware external writes reach flash only with write enabled,
    // and become page erases when erase is enabled too
    assign eff_write = req.op == OP_EXT_WRITE &&
                       (req.from_debug ||
                        (program_store_control_q[CTRL_WR_EN] &&
                         !program_store_control_q[CTRL_ER_EN]));
    assign eff_erase = req.from_debug ? req.op == OP_PAGE_ERASE :
                       (req.op == OP_EXT_WRITE &&
                        program_store_control_q[CTRL_WR_EN] &&
                        program_store_control_q[CTRL_ER_EN]);
    assign to_aux = !req.from_debug &&
                    (req.op == OP_EXT_READ ||
                     (req.op == OP_EXT_WRITE &&
                      !program_store_control_q[CTRL_WR_EN]));
    assign is_lock_page = !tgt_scratch &&
                          req.addr[15:PAGE_SHIFT] == LOCK_PAGE;
    assign id_read = is_read && req.addr == PART_ID_ADDR;
    assign in_reserved = req.addr >= RSV_BASE && !id_read;
    assign monitor_ok = reset_cause_register_q[CAUSE_MON_EN] &&
                        reset_cause_register_q[CAUSE_MON_RST];

    always_comb begin
        deny = 1'b0;
        // aux ram traffic never touches flash, so no flash rule applies
        if (to_aux) begin
            deny = 1'b0;
        end else if (req.op == OP_FETCH) begin
            deny = tgt_scratch;
        end else if (in_reserved) begin
            deny = 1'b1;
        end else if (!req.from_debug && (eff_write || eff_erase) &&
                     !monitor_ok) begin
            deny = 1'b1;
        end else if (eff_erase && is_lock_page) begin
            deny = !req.from_debug || any_lock;
        end else if (eff_write && req.addr == LOCK_ADDR &&
                     lock_written_q) begin
            deny = 1'b1;
        end else if (tgt_locked) begin
            deny = req.from_debug || !src_locked;
        end
    end

    // ------------------------------------------------------------
    // verdict registers
    // ------------------------------------------------------------
    logic take;
    logic grant;
    logic [15:0] cmd_addr;

    assign take = req.valid && req_ready;
    assign grant = take && !deny && !to_aux && !id_read &&
                   (is_read || eff_write || eff_erase);
    // erase targets the whole page so the array sets every byte
    assign cmd_addr = eff_erase ? {req.addr[15:PAGE_SHIFT], 10'h000} :
                      req.addr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_cmd <= '0;
        end else if (full_chip_wipe && !latch_pend_q) begin
            flash_cmd.valid <= 1'b1;
            flash_cmd.scratch <= 1'b1;
            flash_cmd.kind <= FK_WIPE;
            flash_cmd.addr <= 16'h0000;
            flash_cmd.wdata <= 8'h00;
        end else begin
            flash_cmd.valid <= grant;
            flash_cmd.scratch <= tgt_scratch;
            flash_cmd.kind <= eff_erase ? FK_ERASE :
                              (eff_write ? FK_WRITE : FK_READ);
            flash_cmd.addr <= cmd_addr;
            flash_cmd.wdata <= req.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_q <= 1'b0;
            debug_ignored <= 1'b0;
            aux_ram_sel <= 1'b0;
        end else begin
            fault_q <= take && deny && !req.from_debug;
            debug_ignored <= take && deny && req.from_debug;
            aux_ram_sel <= take && to_aux && !deny;
        end
    end

    assign flash_fault_device_reset = fault_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            id_valid <= 1'b0;
            id_data <= 8'h00;
        end else begin
            id_valid <= take && id_read;
            id_data <= PART_ID;
        end
    end

    // once any write hits the lock byte it stays frozen until a wipe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_written_q <= 1'b0;
        end else if (latch_pend_q) begin
            lock_written_q <= lock_byte_in != LOCK_ERASED;
        end else if (full_chip_wipe) begin
            lock_written_q <= 1'b0;
        end else if (grant && eff_write && req.addr == LOCK_ADDR) begin
            lock_written_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_fetch_scratch_fault: assert property (
        take && req.op == OP_FETCH && tgt_scratch && !req.from_debug
        |=> flash_fault_device_reset && !flash_cmd.valid)
        else $error("scratchpad fetch not faulted");
    a_debug_no_reset: assert property (
        take && req.from_debug |=> !flash_fault_device_reset)
        else $error("debug access caused reset");
    a_reserved_closed: assert property (
        take && req.addr >= RSV_BASE && req.op != OP_CODE_READ &&
        req.op != OP_EXT_READ |=> !flash_cmd.valid)
        else $error("reserved area reached");
    a_locked_debug_ignored: assert property (
        take && req.from_debug && tgt_locked && req.op != OP_FETCH
        |=> debug_ignored)
        else $error("debug access to locked page not ignored");
    a_fault_sets_flag: assert property (
        flash_fault_device_reset |=> reset_cause_register_q[CAUSE_FAULT])
        else $error("fault flag not set");
    a_monitor_fault: assert property (
        take && !req.from_debug && (eff_write || eff_erase) && !monitor_ok
        |=> flash_fault_device_reset)
        else $error("modify without monitor not faulted");
    a_fw_lock_erase: assert property (
        take && !req.from_debug && eff_erase && is_lock_page
        |=> flash_fault_device_reset)
        else $error("firmware lock page erase not faulted");
    a_lock_stable: assert property (
        !latch_pend_q && !fault_q && !full_chip_wipe
        |=> $stable(lock_n_q))
        else $error("lock decode changed mid-run");
    a_wipe_unlocks: assert property (
        full_chip_wipe && !latch_pend_q && !fault_q
        |=> lock_n_q == 8'h00 ##0 flash_cmd.kind == FK_WIPE)
        else $error("wipe did not unlock");
    a_ext_read_aux: assert property (
        take && !req.from_debug && req.op == OP_EXT_READ
        |=> aux_ram_sel && !flash_cmd.valid)
        else $error("external read reached flash");

    c_fault_seen: cover property (take ##1 flash_fault_device_reset);
    c_erase_granted: cover property (
        flash_cmd.valid && flash_cmd.kind == FK_ERASE);
    c_debug_dropped: cover property (debug_ignored);
    c_id_read: cover property (id_valid);

endmodule

`default_nettype wire

/* flash_guard_pkg.sv */
// Purpose: shared constants and types for the flash access security guard
// Assumes: 64 KB program flash in 1024-byte pages, byte-wide data
// Notes:   register map sits on a 32-bit AHB-Lite slave
//
// Summary of operation
// - scratchpad replaces low page when enabled
// - no instruction fetch from the scratchpad
// - firmware external-move reads go to auxiliary RAM
// - firmware modify needs write enable, erase both
// - lock byte complement gives locked page count
// - lock byte page locked when any bit clear
// - unlocked pages open to every source
// - locked page: debug ignored, unlocked code faults
// - lock page reads follow locked-page policy
// - firmware lock page erase always faults
// - written lock byte is frozen until wipe
// - reserved area closed to every source
// - forbidden debug accesses are silently dropped
// - fault reset sets the fault flag
// - full-chip wipe erases all, unlocks everything
// - full-chip wipe also clears the scratchpad
// - scratchpad locked when all pages locked
// - lock decode is latched only at reset
// - part identification byte read at 0xFFFE
// - modify without supply monitor causes fault
// - supply monitor enables set after power-on
// - erase is whole page to 0xFF
package flash_guard_pkg;

    // ------------------------------------------------------------
    // address map of the flash
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int PAGE_SHIFT = 10;
    localparam logic [15:0] SCRATCH_LAST = 16'h03FF;
    localparam logic [15:0] LOCK_ADDR = 16'hFBFF;
    localparam logic [5:0] LOCK_PAGE = 6'h3E;
    localparam logic [15:0] RSV_BASE = 16'hFC00;
    localparam logic [15:0] PART_ID_ADDR = 16'hFFFE;
    localparam logic [7:0] LOCK_ERASED = 8'hFF;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CAUSE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam int CTRL_WR_EN = 0;
    localparam int CTRL_ER_EN = 1;
    localparam int CTRL_SCR_EN = 2;
    localparam int CAUSE_POR = 0;
    localparam int CAUSE_MON_EN = 1;
    localparam int CAUSE_MON_RST = 2;
    localparam int CAUSE_FAULT = 3;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [3:0] CAUSE_RESET = 4'h7;
    localparam int STAT_WRITTEN = 8;
    localparam int STAT_ID_LSB = 16;

    typedef enum logic [2:0] {
        OP_FETCH,
        OP_CODE_READ,
        OP_EXT_READ,
        OP_EXT_WRITE,
        OP_PAGE_ERASE
    } access_op_t;

    typedef enum logic [1:0] {
        FK_READ,
        FK_WRITE,
        FK_ERASE,
        FK_WIPE
    } flash_kind_t;

    typedef struct packed {
        logic valid;
        logic from_debug;
        access_op_t op;
        logic [15:0] addr;
        logic [15:0] fetch_addr;
        logic [7:0] wdata;
    } access_req_t;

    typedef struct packed {
        logic valid;
        logic scratch;
        flash_kind_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
    } flash_cmd_t;

endpackage

/* flash_array_model.sv */
// Purpose: behavioural flash array facing the access guard
// Assumes: only the lock byte matters to the guard, so only it is stored
// Notes:   the stored byte survives guard resets, like real flash cells
`timescale 1ns/1ns
`default_nettype none

module flash_array_model
    import flash_guard_pkg::*;
(
    // clock
    input wire logic hclk,
    // commands from the guard
    input wire flash_cmd_t flash_cmd,
    // stored lock byte
    output logic [7:0] lock_byte_in
);
    // --------------------------------------------------------------
    // lock byte cell
    // --------------------------------------------------------------
    logic [7:0] lock_q = LOCK_ERASED;

    always @(posedge hclk) begin
        if (flash_cmd.valid && flash_cmd.kind == FK_WIPE) begin
            lock_q <= LOCK_ERASED;
        end else if (flash_cmd.valid && !flash_cmd.scratch) begin
            if (flash_cmd.kind == FK_ERASE &&
                flash_cmd.addr[15:10] == LOCK_PAGE) begin
                lock_q <= LOCK_ERASED;
            end else if (flash_cmd.kind == FK_WRITE &&
                         flash_cmd.addr == LOCK_ADDR) begin
                // a write can only clear bits
                lock_q <= lock_q & flash_cmd.wdata;
            end
        end
    end

    assign lock_byte_in = lock_q;

endmodule
`default_nettype wire

/* flash_access_security_guard_test.sv */
// Purpose: self-checking bench for the flash access guard
// Assumes: each taken request gets its verdict one edge later
// Notes:   fixed-seed random traffic mixed with lock corner cases
`timescale 1ns/1ns
`default_nettype none

module flash_access_security_guard_test
    import flash_guard_pkg::*;
;
    localparam logic [7:0] PID = 8'h3C; // arbitrary value

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    access_req_t req = '0;
    logic req_ready;
    logic full_chip_wipe = 1'b0;
    logic [7:0] lock_byte_in;
    flash_cmd_t flash_cmd;
    logic aux_ram_sel, debug_ignored, flash_fault_device_reset, id_valid;
    logic [7:0] id_data;
    int err_count = 0;
    int tests_run = 0;
    int seed = 32'hE09205AD;
    logic [2:0] ctrl_m;
    logic [3:0] cause_m;
    logic [7:0] lock_m = 8'hFF;
    logic [7:0] n_m;
    logic wr_m;

    flash_access_guard #(.PART_ID(PID)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .req(req), .req_ready(req_ready),
        .full_chip_wipe(full_chip_wipe), .lock_byte_in(lock_byte_in),
        .flash_cmd(flash_cmd), .aux_ram_sel(aux_ram_sel),
        .debug_ignored(debug_ignored),
        .flash_fault_device_reset(flash_fault_device_reset),
        .id_valid(id_valid), .id_data(id_data)
    );

    flash_array_model model_u (
        .hclk(hclk), .flash_cmd(flash_cmd), .lock_byte_in(lock_byte_in)
    );

    always #20 hclk = ~hclk;

    // --------------------------------------------------------------
    // checking and ending
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // verdict bits: grant, aux ram, ignored, fault, id; kind and scratch
    function automatic logic [7:0] exp_v(input logic dbg,
        input access_op_t op, input logic [15:0] a, input logic [15:0] f);
        logic scr, fl, lk, wr, er;
        logic [5:0] pg;
        pg = a[15:10];
        scr = ctrl_m[CTRL_SCR_EN] && a <= SCRATCH_LAST;
        fl = f[15:10] < n_m || (f[15:10] == LOCK_PAGE && n_m != 0);
        lk = scr ? n_m >= 62 : pg < n_m || (pg == LOCK_PAGE && n_m != 0);
        wr = op == OP_EXT_WRITE && (dbg || ctrl_m[CTRL_WR_EN]);
        er = dbg ? op == OP_PAGE_ERASE : wr && ctrl_m[CTRL_ER_EN];
        if (op == OP_EXT_READ && !dbg) return 8'h08;
        if (op == OP_FETCH) return scr ? (dbg ? 8'h04 : 8'h02) : 8'h00;
        if (op == OP_EXT_WRITE && !wr) return 8'h08;
        if (op == OP_CODE_READ && a == PART_ID_ADDR) return 8'h01;
        if (a >= RSV_BASE) return dbg ? 8'h04 : 8'h02;
        if (!dbg && wr && !(cause_m[1] && cause_m[2])) return 8'h02;
        if (er && pg == LOCK_PAGE) begin
            return dbg ? (n_m == 0 ? {FK_ERASE, 1'b0, 5'h10} : 8'h04) : 8'h02;
        end
        if (wr && !er && a == LOCK_ADDR && wr_m) return dbg ? 8'h04 : 8'h02;
        if (lk && (dbg || !fl)) return dbg ? 8'h04 : 8'h02;
        if (op == OP_EXT_READ) return 8'h00;
        return {er ? FK_ERASE : wr ? FK_WRITE : FK_READ, scr, 5'h10};
    endfunction

    // --------------------------------------------------------------
    // bus and request drivers
    // --------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        check(r, e);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
        if (a == OFS_CTRL) ctrl_m = d[2:0];
        if (a == OFS_CAUSE) cause_m = d[3:0];
    endtask

    task automatic send(input logic dbg, input access_op_t op,
        input logic [15:0] a, input logic [15:0] f, input logic [7:0] d);
        logic [7:0] e;
        e = exp_v(dbg, op, a, f);
        @(posedge hclk);
        req <= '{1'b1, dbg, op, a, f, d};
        @(negedge hclk);
        while (req_ready !== 1'b1) begin
            @(negedge hclk);
        end
        @(posedge hclk);
        req.valid <= 1'b0;
        @(negedge hclk);
        check({flash_cmd.valid, aux_ram_sel, debug_ignored,
               flash_fault_device_reset, id_valid}, e[4:0]);
        if (e[4]) begin
            check({flash_cmd.kind, flash_cmd.scratch}, e[7:5]);
            check(flash_cmd.addr, e[7:6] == FK_ERASE ?
                  {a[15:10], 10'h0} : a);
            if (e[7:6] == FK_WRITE) check(flash_cmd.wdata, d);
        end
        if (e[0]) check(id_data, PID);
    endtask

    task automatic do_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        ctrl_m = CTRL_RESET;
        cause_m = CAUSE_RESET;
        n_m = ~lock_m;
        wr_m = lock_m != LOCK_ERASED;
    endtask

    task automatic rand_phase(input int cnt);
        logic [31:0] r;
        access_op_t op;
        logic [15:0] a;
        for (int i = 0; i < cnt; i++) begin
            if (i % 16 == 0) wr_reg(OFS_CTRL, $random(seed) & 32'h7);
            r = $random(seed);
            op = r[2:1] == 2'h0 ? OP_CODE_READ : r[2:1] == 2'h1 ?
                 OP_EXT_READ : r[2:1] == 2'h2 ? OP_EXT_WRITE :
                 r[0] ? OP_PAGE_ERASE : OP_CODE_READ;
            a = {6'(r[8:3] % 6'd62), r[18:9]};
            if (r[21:19] == 3'h0) a = {6'h3F, r[18:9]};
            send(r[0], op, a, {6'(r[27:22] % 6'd62), 10'h0}, r[31:24]);
        end
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        #(40 * 60000);
        err_count++;
        stop_test;
    end

    initial begin
        do_reset;
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_CAUSE, 32'h7);
        rd_chk(OFS_STATUS, {8'h00, PID, 16'h0000});
        rd_chk(8'h0C, 32'h0);
        rand_phase(150);
        wr_reg(OFS_CTRL, 32'h7);
        send(1'b0, OP_FETCH, 16'h0100, 16'h0800, 8'h00);
        rd_chk(OFS_CAUSE, 32'hF);
        wr_reg(OFS_CAUSE, 32'h5);
        wr_reg(OFS_CTRL, 32'h1);
        send(1'b0, OP_EXT_WRITE, 16'h1400, 16'h0800, 8'h00);
        wr_reg(OFS_CAUSE, 32'h7);
        send(1'b0, OP_EXT_WRITE, LOCK_ADDR, 16'h0C00, 8'hFD);
        lock_m = 8'hFD;
        wr_m = 1'b1;
        send(1'b1, OP_CODE_READ, 16'h0400, 16'h0, 8'h0);
        do_reset;
        rd_chk(OFS_STATUS, {8'h00, PID, 7'h00, wr_m, n_m});
        rand_phase(150);
        send(1'b1, OP_CODE_READ, LOCK_ADDR, 16'h0, 8'h0);
        send(1'b1, OP_PAGE_ERASE, LOCK_ADDR, 16'h0, 8'h0);
        wr_reg(OFS_CTRL, 32'h3);
        send(1'b0, OP_EXT_WRITE, LOCK_ADDR, 16'h0000, 8'h0);
        wr_reg(OFS_CTRL, 32'h1);
        send(1'b0, OP_EXT_WRITE, LOCK_ADDR, 16'h0000, 8'h0);
        send(1'b1, OP_EXT_WRITE, LOCK_ADDR, 16'h0, 8'h0);
        @(posedge hclk);
        full_chip_wipe <= 1'b1;
        @(posedge hclk);
        full_chip_wipe <= 1'b0;
        @(negedge hclk);
        check({flash_cmd.valid, flash_cmd.kind, flash_cmd.scratch},
              {1'b1, FK_WIPE, 1'b1});
        lock_m = 8'hFF;
        n_m = 8'h00;
        wr_m = 1'b0;
        rd_chk(OFS_STATUS, {8'h00, PID, 16'h0000});
        send(1'b1, OP_CODE_READ, 16'h0000, 16'h0, 8'h0);
        send(1'b0, OP_EXT_WRITE, LOCK_ADDR, 16'h0C00, 8'hC1);
        lock_m = 8'hC1;
        do_reset;
        wr_reg(OFS_CTRL, 32'h5);
        send(1'b1, OP_CODE_READ, 16'h0010, 16'h0, 8'h0);
        send(1'b0, OP_CODE_READ, 16'h0010, 16'hFC00, 8'h0);
        send(1'b0, OP_CODE_READ, 16'h0010, 16'h0400, 8'h0);
        stop_test;
    end

endmodule
`default_nettype wire
